// ===== pkg/lsr_pkg.sv
// lsr_pkg: register map, field positions, reset values and carrier types
// for the segment store and frame clocking block.
// assumes a 32-bit axi4-lite register bus with byte addresses.
package lsr_pkg;

	// geometry of the display
	localparam int FP_NUM    = 40;
	localparam int BP_MAX    = 4;
	localparam int SEG_BITS  = 160;
	localparam int SEG_WORDS = 5;
	localparam int ADDR_W    = 8;

	// register byte offsets
	localparam logic [7:0] OFF_SEG0    = 8'h00;
	localparam logic [7:0] OFF_CTRL    = 8'h20;
	localparam logic [7:0] OFF_FPEN_LO = 8'h24;
	localparam logic [7:0] OFF_FPEN_HI = 8'h28;
	localparam logic [7:0] OFF_STATUS  = 8'h2C;

	// control register fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_DUTY_LSB = 1;
	localparam int CTRL_PRE_LSB  = 4;
	localparam logic [2:0] PRE_RST  = 3'h6;
	localparam logic [1:0] DUTY_RST = 2'h3;

	// status register fields
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_INV_BIT   = 2;
	localparam int STAT_FRAME_LSB = 8;

	// frame clocking: divider = 2 ** (base + prescale code)
	localparam int RC_FREQ_HZ    = 16_000_000;
	localparam int DIV_LOG2_BASE = 10;
	localparam int DIV_CNT_W     = 17;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [2:0] prescale;
		logic [1:0] duty;
		logic       enable;
	} lsr_ctrl_t;

	typedef struct packed {
		logic [7:0] frame_cnt;
		logic       invert;
		logic [1:0] phase;
	} lsr_scan_t;

endpackage

// ===== rtl/lsr_frame_timer.sv
// lsr_frame_timer: counts edges of the internal rc clock pin and emits
// one aclk pulse each time the selected divider is reached.
// assumes the rc clock is asynchronous to aclk.
`timescale 1ns/1ns
module lsr_frame_timer #(
	parameter int DIV_LOG2_BASE = lsr_pkg::DIV_LOG2_BASE
) (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// rc clock pin and divider code
	input  wire logic       internal_rc_clock,
	input  wire logic [2:0] prescale,
	// divided tick
	output logic            step
);
	localparam int CW = lsr_pkg::DIV_CNT_W;

	if (DIV_LOG2_BASE < 0 || DIV_LOG2_BASE + 7 > CW) begin : g_bad_base
		$error("lsr_frame_timer: bad base");
	end

	logic          rc_meta_r;
	logic          rc_sync_r;
	logic          rc_prev_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] last;
	logic          rc_rise;

	// limitation: edges closer than two aclk periods alias, so the
	// real divider is only honoured when aclk is fast enough
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_meta_r <= 1'b0;
			rc_sync_r <= 1'b0;
			rc_prev_r <= 1'b0;
		end else begin
			rc_meta_r <= internal_rc_clock;
			rc_sync_r <= rc_meta_r;
			rc_prev_r <= rc_sync_r;
		end
	end

	assign rc_rise = rc_sync_r & ~rc_prev_r;
	// 110 -> 65536, 111 -> 131072 with the default base
	assign last = CW'((64'h1 << (DIV_LOG2_BASE + int'(prescale))) - 64'h1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			step  <= 1'b0;
		end else begin
			step <= 1'b0;
			if (rc_rise) begin
				if (cnt_r >= last) begin
					cnt_r <= '0;
					step  <= 1'b1;
				end else begin
					cnt_r <= cnt_r + CW'(1);
				end
			end
		end
	end
endmodule // lsr_frame_timer

// ===== rtl/lsr_seg_store.sv
// lsr_seg_store: 160-bit segment store, word-wide bus port plus a
// second read port that exposes every bit to the scanner.
// assumes one writer; contents are not reset.
`timescale 1ns/1ns
module lsr_seg_store #(
	parameter int WORDS = lsr_pkg::SEG_WORDS
) (
	// clock
	input  wire logic                  aclk,
	// bus port
	input  wire logic                  wr_en,
	input  wire logic [2:0]            wr_idx,
	input  wire logic [31:0]           wr_data,
	input  wire logic [3:0]            wr_strb,
	input  wire logic [2:0]            rd_idx,
	output logic      [31:0]           rd_data,
	// scan port
	output logic      [WORDS*32-1:0]   scan_bits
);
	if (WORDS < 1 || WORDS > 8) begin : g_bad_words
		$error("lsr_seg_store: WORDS out of range");
	end

	// no reset on purpose: software must fill it before enabling
	logic [31:0] mem [WORDS];

	for (genvar w = 0; w < WORDS; w++) begin : g_word
		for (genvar b = 0; b < 4; b++) begin : g_lane
			always_ff @(posedge aclk) begin
				if (wr_en && wr_idx == 3'(w) && wr_strb[b]) begin
					mem[w][8*b +: 8] <= wr_data[8*b +: 8];
				end
			end
		end
		assign scan_bits[32*w +: 32] = mem[w];
	end

	assign rd_data = (int'(rd_idx) < WORDS) ? mem[rd_idx] : 32'h0000_0000;
endmodule // lsr_seg_store

// ===== rtl/lsr_segment_display.sv
// lsr_segment_display: axi4-lite slave holding the segment store,
// driver controls and the backplane scan that drives the panel pins.
// assumes the rc clock pin is asynchronous; bias levels are off chip.
//
// Behaviour
// - 160 store bits, one per segment
// - stored one drives on, if enables set
// - stored zero drives the off waveform
// - store dual ported, bus and scanner
// - bus reads return stored bits
// - driver off: store acts as ram
// - enable bit access leaves store alone
// - store not initialised by reset
// - prescale 110/111 give 65536/131072
// - frame rate is rc/divider times duty
// - frontplane waits for driver enable
// - duty 1/1 to 1/4, scan backplanes
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module lsr_segment_display #(
	parameter int DIV_LOG2_BASE = lsr_pkg::DIV_LOG2_BASE
) (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic [lsr_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read address
	input  wire logic [lsr_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// rc clock pin
	input  wire logic                        internal_rc_clock,
	// panel drivers
	output logic [lsr_pkg::FP_NUM-1:0]       fp_out,
	output logic [lsr_pkg::FP_NUM-1:0]       fp_oe,
	output logic [lsr_pkg::BP_MAX-1:0]       bp_out,
	output logic [lsr_pkg::BP_MAX-1:0]       bp_oe
);
	localparam int FPN = lsr_pkg::FP_NUM;
	localparam int BPN = lsr_pkg::BP_MAX;

	// refuse geometries that the scan, the map and the divider cannot serve
	if (lsr_pkg::SEG_BITS != FPN * BPN) begin : g_bad_size
		$error("lsr: store size mismatch");
	end
	if (lsr_pkg::SEG_WORDS * 32 != lsr_pkg::SEG_BITS) begin : g_bad_words
		$error("lsr: store words do not cover the segments");
	end
	if (BPN != 4) begin : g_bad_bp
		$error("lsr: phase and duty fields assume four backplanes");
	end
	if (FPN <= 32 || FPN > 40) begin : g_bad_fp
		$error("lsr: frontplane enables span one full and one partial word");
	end
	if (DIV_LOG2_BASE < 0 || DIV_LOG2_BASE + 7 > lsr_pkg::DIV_CNT_W) begin : g_bad_base
		$error("lsr: divider base does not fit the counter");
	end

	// register decode shared by the read and write paths
	function automatic logic is_seg(input logic [lsr_pkg::ADDR_W-1:0] a);
		return a[7:2] < 6'(lsr_pkg::SEG_WORDS) && a[7:5] == 3'h0;
	endfunction

	function automatic logic is_mapped(input logic [lsr_pkg::ADDR_W-1:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		return is_seg(a) || w == lsr_pkg::OFF_CTRL || w == lsr_pkg::OFF_FPEN_LO
			|| w == lsr_pkg::OFF_FPEN_HI || w == lsr_pkg::OFF_STATUS;
	endfunction

	// registers
	lsr_pkg::lsr_ctrl_t       ctrl_r;
	logic [FPN-1:0]           fpen_r;
	lsr_pkg::lsr_scan_t       scan_r;

	// write channel capture
	logic                      aw_held_r;
	logic                      w_held_r;
	logic [lsr_pkg::ADDR_W-1:0] aw_addr_r;
	logic [31:0]               w_data_r;
	logic [3:0]                w_strb_r;
	logic                      wr_fire;
	logic [7:0]                wr_word;
	logic                      wr_store;
	logic [1:0]                wr_resp;

	// read channel
	logic [31:0]               store_rd;
	logic [31:0]               rd_value;
	logic [7:0]                rd_word;
	logic [1:0]                rd_resp;

	// scan
	logic [lsr_pkg::SEG_BITS-1:0] seg_bits;
	logic [FPN-1:0]            col_r;
	logic                      step;
	logic [1:0]                phase_last;
	logic [1:0]                phase_d_r;
	logic                      invert_d_r;

	// write path: address and data taken in either order
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_word       = {aw_addr_r[7:2], 2'b00};
	assign wr_store      = wr_fire && is_seg(aw_addr_r);
	// unmapped words answer decerr and change nothing
	assign wr_resp       = is_mapped(aw_addr_r) ? lsr_pkg::RESP_OKAY : lsr_pkg::RESP_DECERR;

	// write select shared by the register processes
	function automatic logic wr_hit(input logic [7:0] off);
		return wr_fire && wr_word == off;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= lsr_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_resp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register; the store is a separate array, so touching the
	// enable bit can never disturb it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.enable   <= 1'b0;
			ctrl_r.duty     <= lsr_pkg::DUTY_RST;
			ctrl_r.prescale <= lsr_pkg::PRE_RST;
		end else if (wr_hit(lsr_pkg::OFF_CTRL) && w_strb_r[0]) begin
			ctrl_r.enable   <= w_data_r[lsr_pkg::CTRL_EN_BIT];
			ctrl_r.duty     <= w_data_r[lsr_pkg::CTRL_DUTY_LSB +: 2];
			ctrl_r.prescale <= w_data_r[lsr_pkg::CTRL_PRE_LSB +: 3];
		end
	end

	// frontplane enables, byte lanes honoured
	for (genvar b = 0; b < 4; b++) begin : g_fpen_lo
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				fpen_r[8*b +: 8] <= 8'h00;
			end else if (wr_hit(lsr_pkg::OFF_FPEN_LO) && w_strb_r[b]) begin
				fpen_r[8*b +: 8] <= w_data_r[8*b +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fpen_r[FPN-1:32] <= 8'h00;
		end else if (wr_hit(lsr_pkg::OFF_FPEN_HI) && w_strb_r[0]) begin
			fpen_r[FPN-1:32] <= w_data_r[FPN-33:0];
		end
	end

	// store: bus on one port, scanner on the other; no reset, no gating by
	// the enable bit, so with the driver off it is plain ram
	lsr_seg_store #(
		.WORDS (lsr_pkg::SEG_WORDS)
	) u_store (
		.aclk      (aclk),
		.wr_en     (wr_store),
		.wr_idx    (aw_addr_r[4:2]),
		.wr_data   (w_data_r),
		.wr_strb   (w_strb_r),
		.rd_idx    (s_axi_araddr[4:2]),
		.rd_data   (store_rd),
		.scan_bits (seg_bits)
	);

	// read path: one cycle from the address handshake to rvalid
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_word       = {s_axi_araddr[7:2], 2'b00};
	assign rd_resp       = is_mapped(s_axi_araddr) ? lsr_pkg::RESP_OKAY : lsr_pkg::RESP_DECERR;

	always_comb begin
		rd_value = 32'h0000_0000;
		if (is_seg(s_axi_araddr)) begin
			rd_value = store_rd;
		end else begin
			case (rd_word)
				lsr_pkg::OFF_CTRL: begin
					rd_value[lsr_pkg::CTRL_EN_BIT]        = ctrl_r.enable;
					rd_value[lsr_pkg::CTRL_DUTY_LSB +: 2] = ctrl_r.duty;
					rd_value[lsr_pkg::CTRL_PRE_LSB +: 3]  = ctrl_r.prescale;
				end
				lsr_pkg::OFF_FPEN_LO: rd_value = fpen_r[31:0];
				lsr_pkg::OFF_FPEN_HI: rd_value[FPN-33:0] = fpen_r[FPN-1:32];
				lsr_pkg::OFF_STATUS: begin
					rd_value[lsr_pkg::STAT_PHASE_LSB +: 2] = scan_r.phase;
					rd_value[lsr_pkg::STAT_INV_BIT]        = scan_r.invert;
					rd_value[lsr_pkg::STAT_FRAME_LSB +: 8] = scan_r.frame_cnt;
				end
				default: rd_value = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= lsr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// frame clock: one backplane phase per divided tick, so a frame of
	// n phases runs at rc / divider / n
	lsr_frame_timer #(
		.DIV_LOG2_BASE (DIV_LOG2_BASE)
	) u_timer (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.internal_rc_clock (internal_rc_clock),
		.prescale          (ctrl_r.prescale),
		.step              (step)
	);

	assign phase_last = ctrl_r.duty;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_r.phase     <= 2'h0;
			scan_r.invert    <= 1'b0;
			scan_r.frame_cnt <= 8'h00;
		end else if (!ctrl_r.enable) begin
			scan_r.phase <= 2'h0;
		end else if (step) begin
			if (scan_r.phase >= phase_last) begin
				scan_r.phase     <= 2'h0;
				// alternate polarity each frame to keep the panel dc free
				scan_r.invert    <= ~scan_r.invert;
				scan_r.frame_cnt <= scan_r.frame_cnt + 8'h01;
			end else begin
				scan_r.phase <= scan_r.phase + 2'h1;
			end
		end
	end

	// column sample: the scanner reads its own port each cycle, so it
	// never waits on the bus and a write shows within one cycle
	for (genvar f = 0; f < FPN; f++) begin : g_col
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				col_r[f] <= 1'b0;
			end else begin
				col_r[f] <= seg_bits[f*BPN + int'(scan_r.phase)];
			end
		end
	end

	// scan state delayed one cycle to line up with the column sample, so
	// backplane and frontplane pins turn on the same edge and add no dc step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_d_r  <= 2'h0;
			invert_d_r <= 1'b0;
		end else begin
			phase_d_r  <= scan_r.phase;
			invert_d_r <= scan_r.invert;
		end
	end

	// frontplane pins: a set bit is driven opposite to the selected
	// backplane (on), a clear bit in step with it (off)
	for (genvar f = 0; f < FPN; f++) begin : g_fp
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				fp_out[f] <= 1'b0;
				fp_oe[f]  <= 1'b0;
			end else begin
				fp_out[f] <= col_r[f] ? ~invert_d_r : invert_d_r;
				fp_oe[f]  <= ctrl_r.enable && fpen_r[f];
			end
		end
	end

	// backplane pins: only the backplanes the duty mode uses are driven
	for (genvar k = 0; k < BPN; k++) begin : g_bp
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				bp_out[k] <= 1'b0;
				bp_oe[k]  <= 1'b0;
			end else begin
				bp_out[k] <= (phase_d_r == 2'(k)) ? invert_d_r : ~invert_d_r;
				bp_oe[k]  <= ctrl_r.enable && (2'(k) <= ctrl_r.duty);
			end
		end
	end
endmodule // lsr_segment_display

// ===== verification/lsr_panel_model.sv
// lsr_panel_model: rc clock source and a panel that reports which segments are lit.
// assumes the odd backplane is the active one; fp settles within 3 cycles of a phase.
`timescale 1ns/1ns
module lsr_panel_model (
	// clock
	input  wire logic         aclk,
	// rc clock pin
	output logic              internal_rc_clock,
	// panel pins
	input  wire logic [39:0]  fp_out,
	input  wire logic [39:0]  fp_oe,
	input  wire logic [3:0]   bp_out,
	// decoded view
	output logic [159:0]      seg_seen,
	output logic              pol
);
	logic [1:0] phase;
	logic [3:0] last;
	int         still;

	// 8 aclk per rc period, slow enough that every rising rc edge is counted
	initial begin
		internal_rc_clock = 1'b0;
		#57;
		forever #160 internal_rc_clock = ~internal_rc_clock;
	end

	always_comb begin
		pol = ($countones(bp_out) == 1);
		phase = 2'h0;
		for (int k = 0; k < 4; k++)
			if (bp_out[k] == pol) phase = 2'(k);
	end

	// lit means frontplane opposite to the active backplane
	always @(posedge aclk) begin
		still <= (bp_out == last) ? still + 1 : 0;
		last <= bp_out;
		if (still >= 3)
			for (int f = 0; f < 40; f++)
				seg_seen[f*4+phase] <= fp_oe[f] & (fp_out[f] ^ pol);
	end
endmodule // lsr_panel_model

// ===== verification/lsr_segment_display_props.sv
// lsr_segment_display_props: port-level checks of the segment display block.
// assumes a bind onto lsr_segment_display; reset synchronous, active low.
`timescale 1ns/1ns
module lsr_segment_display_props #(
	parameter int DIV_LOG2_BASE = lsr_pkg::DIV_LOG2_BASE
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write side
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read side
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// panel
	input wire logic [39:0] fp_oe,
	input wire logic [3:0]  bp_out,
	input wire logic [3:0]  bp_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
	write_no_stall_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
		##[1:3] s_axi_bvalid) else $error("write stalled by the scan");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h3})
		else $error("bad write response code");
	fp_gate_a: assert property (|fp_oe |-> bp_oe[0])
		else $error("frontplane driven with driver off");
	bp_mask_a: assert property (bp_oe inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
		else $error("backplane enables not contiguous");
	one_phase_a: assert property (bp_oe[0] |-> $countones(bp_out) inside {1, 3})
		else $error("more than one active backplane");
	phase_hold_a: assert property ($changed(bp_out) && bp_oe[0] |=>
		($stable(bp_out) || $changed(bp_oe) || !bp_oe[0])[*8]) else $error("phase too short");

	cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($changed(bp_out) && bp_oe == 4'hF);
	cover property (&fp_oe);
endmodule // lsr_segment_display_props

// ===== verification/lsr_segment_display_tb_top.sv
// lsr_segment_display_tb_top: random and corner stimulus with self checks.
// assumes the panel model makes the rc clock and decodes the panel pins.
`timescale 1ns/1ns
module lsr_segment_display_tb_top;
	localparam int BASE = 1;
	logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready, rc, pol;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata;
	logic [3:0]   wstrb, bp_out, bp_oe;
	logic [1:0]   bresp, rresp;
	logic [39:0]  fp_out, fp_oe;
	logic [159:0] seg_seen;
	logic [31:0]  words [5];
	int           fails, checks_done, seed, i;

	lsr_segment_display #(.DIV_LOG2_BASE(BASE)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .internal_rc_clock(rc), .fp_out(fp_out), .fp_oe(fp_oe),
		.bp_out(bp_out), .bp_oe(bp_oe));
	lsr_panel_model panel (.aclk(aclk), .internal_rc_clock(rc), .fp_out(fp_out),
		.fp_oe(fp_oe), .bp_out(bp_out), .seg_seen(seg_seen), .pol(pol));

	always #20 aclk = ~aclk;

	function automatic logic [31:0] ctrl(input logic e, input logic [1:0] d, input logic [2:0] p);
		return {25'h0, p, 1'b0, d, e};
	endfunction

	// 8 aclk per rc period; codes 6 and 7 divide by 65536 and 131072 at the
	// full base, scaled down to the bench base
	function automatic int frame_cycles(input logic [1:0] d, input logic [2:0] p);
		longint div;
		div = (p == 3'h7) ? 64'h2_0000 : (p == 3'h6) ? 64'h1_0000
			: longint'(64'h1 << (lsr_pkg::DIV_LOG2_BASE + p));
		return int'((div >> (lsr_pkg::DIV_LOG2_BASE - BASE)) * (d + 1) * 8);
	endfunction

	function automatic logic [159:0] store();
		return {words[4], words[3], words[2], words[1], words[0]};
	endfunction

	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic timeout();
		fails++;
		$display("MISMATCH t=%0t wait ran out", $time);
		tally_and_finish();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				check(bresp, er);
				return;
			end
		end
		timeout();
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rready <= 1'b0;
				check({rresp, rdata}, {er, ed});
				return;
			end
		end
		timeout();
	endtask

	task automatic wait_pol(output int c);
		logic p0;
		p0 = pol;
		for (c = 1; c < 20000; c++) begin
			@(posedge aclk);
			if (pol !== p0) return;
		end
		timeout();
	endtask

	// first interval is partial after the write, so the second one is measured
	task automatic frame_len(input logic [1:0] d, input logic [2:0] p);
		int c, e;
		e = frame_cycles(d, p);
		wr(lsr_pkg::OFF_CTRL, ctrl(1'b1, d, p), 4'hF, lsr_pkg::RESP_OKAY);
		wait_pol(c);
		wait_pol(c);
		check(c >= e - 1 && c <= e + 1, 1'b1);
		check(bp_oe, 4'((5'h1 << (d + 1)) - 5'h1));
	endtask

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		seed = 27859;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 5; i++) begin
			words[i] = $random(seed);
			wr(8'(i * 4), words[i], 4'hF, lsr_pkg::RESP_OKAY);
		end
		wr(lsr_pkg::OFF_SEG0, 32'hA5A5A5A5, 4'h3, lsr_pkg::RESP_OKAY);
		words[0][15:0] = 16'hA5A5;
		for (i = 0; i < 5; i++) rd_chk(8'(i * 4), words[i], lsr_pkg::RESP_OKAY);
		rd_chk(8'h40, 32'h0, lsr_pkg::RESP_DECERR);
		wr(8'h40, $random(seed), 4'hF, lsr_pkg::RESP_DECERR);
		wr(lsr_pkg::OFF_FPEN_LO, 32'hFFFFFFFF, 4'hF, lsr_pkg::RESP_OKAY);
		wr(lsr_pkg::OFF_FPEN_HI, 32'h000000FF, 4'hF, lsr_pkg::RESP_OKAY);
		repeat (4) @(posedge aclk);
		check(fp_oe, 40'h0);
		rd_chk(lsr_pkg::OFF_FPEN_HI, 32'h000000FF, lsr_pkg::RESP_OKAY);
		rd_chk(lsr_pkg::OFF_STATUS, 32'h0, lsr_pkg::RESP_OKAY);
		wr(lsr_pkg::OFF_CTRL, ctrl(1'b1, 2'h3, 3'h0), 4'hF, lsr_pkg::RESP_OKAY);
		rd_chk(lsr_pkg::OFF_CTRL, ctrl(1'b1, 2'h3, 3'h0), lsr_pkg::RESP_OKAY);
		for (i = 0; i < 5; i++) rd_chk(8'(i * 4), words[i], lsr_pkg::RESP_OKAY);
		repeat (300) @(posedge aclk);
		check(seg_seen, store());
		wr(lsr_pkg::OFF_FPEN_LO, 32'h0, 4'hF, lsr_pkg::RESP_OKAY);
		repeat (300) @(posedge aclk);
		check(seg_seen, store() & {32'hFFFFFFFF, 128'h0});
		wr(lsr_pkg::OFF_FPEN_LO, 32'hFFFFFFFF, 4'hF, lsr_pkg::RESP_OKAY);
		words[2] = $random(seed);
		wr(8'h08, words[2], 4'hF, lsr_pkg::RESP_OKAY);
		repeat (300) @(posedge aclk);
		check(seg_seen, store());
		for (i = 0; i < 4; i++) frame_len(2'(i), 3'h0);
		frame_len(2'h0, 3'h6);
		frame_len(2'h0, 3'h7);
		tally_and_finish();
	end
endmodule // lsr_segment_display_tb_top

bind lsr_segment_display lsr_segment_display_props #(.DIV_LOG2_BASE(DIV_LOG2_BASE)) u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.fp_oe(fp_oe), .bp_out(bp_out), .bp_oe(bp_oe));
